//--- dv/tbs_deser_model.sv
`timescale 1ns/1ps
module tbs_deser_model
    import tbs_pkg::*;
#(
    parameter int LOCK_FRAMES = 4
) (
    // Clock and reset.
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // Link from the serializer.
    input  wire logic [TBS_FRAME_W-1:0] link_frame,
    input  wire logic                   link_frame_strobe,
    input  wire logic                   link_drive_en,
    // Lock indicator, high while not locked, and recovered words.
    output logic                        unlocked,
    output logic      [TBS_WORD_W-1:0]  recovered_word,
    output logic                        word_strobe
);
    logic [7:0] good;
    wire        framed = link_frame[11] == TBS_CLK_BIT_START && link_frame[0] == TBS_CLK_BIT_STOP;

    // Locks after LOCK_FRAMES well framed frames in a row; the word bus toggles when not valid so it is trusted only with word_strobe.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            good <= 8'h00;
            unlocked <= 1'b1;
            word_strobe <= 1'b0;
            recovered_word <= 10'h3FF;
        end
        else
        begin
            word_strobe <= 1'b0;
            recovered_word <= ~recovered_word;
            if (!link_drive_en || (link_frame_strobe && !framed))
            begin
                good <= 8'h00;
                unlocked <= 1'b1;
            end
            else if (link_frame_strobe && unlocked)
            begin
                good <= good + 8'h01;
                unlocked <= (good + 8'h01) < 8'(LOCK_FRAMES);
            end
            else if (link_frame_strobe && link_frame[10:1] != TBS_SYNC_PATTERN)
            begin
                word_strobe <= 1'b1;
                recovered_word <= link_frame[10:1];
            end
        end
    end
endmodule // tbs_deser_model

//--- dv/tbs_serializer_props.sv
`timescale 1ns/1ps
module tbs_serializer_props
    import tbs_pkg::*;
(
    // Clock, reset and bus handshake.
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   pclken,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // Pins and link.
    input wire logic                   transmit_clock,
    input wire logic                   resync_request_a,
    input wire logic                   resync_request_b,
    input wire logic                   output_drive_enable,
    input wire logic                   sleep_request_n,
    input wire logic [TBS_FRAME_W-1:0] link_frame,
    input wire logic                   link_frame_strobe,
    input wire logic                   link_drive_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic        tx_prev;
    logic [9:0]  tx_rises;
    logic [9:0]  next_tx_rises;
    logic [4:0]  req_age;
    logic [4:0]  next_req_age;
    logic [10:0] sync_run;
    logic [10:0] next_sync_run;
    wire         sync_frame = link_frame[10:1] == TBS_SYNC_PATTERN;

    // Raw pins are counted, so these counts never lag the block's synchronized view.
    assign next_tx_rises = !sleep_request_n ? 10'h000
                         : (transmit_clock && !tx_prev && tx_rises != 10'h3FF) ? tx_rises + 10'h001
                         : tx_rises;
    assign next_req_age  = !(resync_request_a || resync_request_b) ? 5'h00
                         : (req_age == 5'h1F) ? req_age : req_age + 5'h01;
    assign next_sync_run = !sleep_request_n ? 11'h000
                         : !link_frame_strobe ? sync_run
                         : !sync_frame ? 11'h000
                         : (sync_run == 11'h7FF) ? sync_run : sync_run + 11'h001;

    // Helper counters.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_prev  <= 1'b0;
            tx_rises <= 10'h000;
            req_age  <= 5'h00;
            sync_run <= 11'h000;
        end
        else
        begin
            tx_prev  <= transmit_clock;
            tx_rises <= next_tx_rises;
            req_age  <= next_req_age;
            sync_run <= next_sync_run;
        end
    end

    frame_bits_a: assert property (
        link_frame_strobe |-> link_frame[11] == TBS_CLK_BIT_START && link_frame[0] == TBS_CLK_BIT_STOP)
        else $error("frame without its clock bits");
    frame_gap_a: assert property (
        link_frame_strobe |=> !link_frame_strobe [*3])
        else $error("two frames in one transmit period");
    settle_wait_a: assert property (
        link_frame_strobe && sleep_request_n && $past(sleep_request_n, 4) |-> tx_rises >= 10'h1FE)
        else $error("frame sent before the settle interval");
    sync_payload_a: assert property (
        link_frame_strobe && req_age >= 5'h14 |-> sync_frame)
        else $error("data frame sent while sync requested");
    sync_min_a: assert property (
        link_frame_strobe && !sync_frame && sync_run != 11'h000 |-> sync_run >= 11'h400)
        else $error("sync run shorter than minimum");
    sleep_float_a: assert property (
        !sleep_request_n [*6] |-> !link_drive_en && !link_frame_strobe)
        else $error("link active during sleep");
    drive_float_a: assert property (
        !output_drive_enable [*6] |-> !link_drive_en)
        else $error("line driven with enable low");
    ready_answer_a: assert property (
        psel && penable && !pready && pclken |=> pready)
        else $error("access not answered in time");
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready held longer than one cycle");
    err_with_ready_a: assert property (
        pslverr |-> pready)
        else $error("error flag without ready");
endmodule // tbs_serializer_props

bind tbs_serializer tbs_serializer_props u_props (
    .pclk, .presetn, .pclken, .psel, .penable, .pready, .pslverr, .transmit_clock,
    .resync_request_a, .resync_request_b, .output_drive_enable, .sleep_request_n,
    .link_frame, .link_frame_strobe, .link_drive_en
);

//--- dv/tbs_serializer_test.sv
`timescale 1ns/1ps
module tbs_serializer_test;
    import tbs_pkg::*;
    localparam logic [31:0] ST_DATA  = (32'h1 << TBS_ST_LOCKED_BIT) | (32'h1 << TBS_ST_DRIVE_BIT);
    localparam logic [31:0] ST_SYNC  = ST_DATA | (32'h1 << TBS_ST_SYNC_BIT);
    localparam logic [31:0] ST_SLEEP = 32'h1 << TBS_ST_SLEEP_BIT;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, link_frame_strobe, link_drive_en, unlocked, word_strobe;
    logic        transmit_clock = 1'b0, capture_edge_select = 1'b1, resync_request_b = 1'b0;
    logic        output_drive_enable = 1'b1, sleep_request_n = 1'b0, pclken = 1'b1;
    logic [9:0]  data_in = 10'h000, recovered_word;
    logic [11:0] link_frame;
    logic [33:0] apb_exp;
    logic [9:0]  word_q[$];
    logic [33:0] apb_q[$];
    int          miscompares = 0, checks = 0;

    always #12.5 pclk = ~pclk;
    // Link clock offset so its edges never coincide with pclk.
    initial #7 forever #100 transmit_clock = ~transmit_clock;

    tbs_serializer u_dut (.pclk, .presetn, .pclken, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .data_in, .transmit_clock, .capture_edge_select,
        .resync_request_a(unlocked), .resync_request_b, .output_drive_enable,
        .sleep_request_n, .link_frame, .link_frame_strobe, .link_drive_en);
    tbs_deser_model u_far (.pclk, .presetn, .link_frame, .link_frame_strobe, .link_drive_en,
        .unlocked, .recovered_word, .word_strobe);

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One bus access; the expected answer is queued for the monitor.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] rd, input logic err);
        int n;
        apb_q.push_back({!wr, err, rd});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        // A slave that never answers counts as a mismatch; the request is still released.
        if (pready !== 1'b1)
            check("pready", 32'h1, 32'(pready));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Waits until the far side is locked and plain data frames flow.
    task automatic wait_data();
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (!(unlocked === 1'b0 && link_frame_strobe === 1'b1 &&
                 link_frame[10:1] !== TBS_SYNC_PATTERN) && n < 20000);
        if (n == 20000)
            check("data flow", 32'h1, 32'h0);
    endtask

    // Words change two cycles after the non-capture edge, well clear of both edges.
    task automatic send_words(input int count);
        logic [9:0] w;
        repeat (count)
        begin
            if (capture_edge_select)
                @(negedge transmit_clock);
            else
                @(posedge transmit_clock);
            repeat (2) @(posedge pclk);
            w = 10'($urandom);
            if (w == TBS_SYNC_PATTERN)
                w = ~w;
            data_in <= w;
            word_q.push_back(w);
        end
        repeat (24) @(posedge pclk);
    endtask

    // Matches results oldest first; repeats of a held word are not expected and pass unchecked.
    always @(posedge pclk)
    begin
        if (word_strobe === 1'b1 && word_q.size() > 0)
            check("recovered_word", 32'(word_q.pop_front()), 32'(recovered_word));
        if (pready === 1'b1 && apb_q.size() > 0)
        begin
            apb_exp = apb_q.pop_front();
            check("pslverr", 32'(apb_exp[32]), 32'(pslverr));
            if (apb_exp[33])
                check("prdata", apb_exp[31:0], prdata);
        end
    end

    initial
    begin
        repeat (90000) @(posedge pclk);
        check("watchdog", 32'h0, 32'h1);
        stop_test();
    end

    initial
    begin
        void'($urandom(32'h69FCC972));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, TBS_CTRL_OFS, 32'h0, {30'h0, TBS_CTRL_RST}, 1'b0);
        apb(1'b0, TBS_STATUS_OFS, 32'h0, ST_SLEEP, 1'b0);
        apb(1'b1, 12'h010, 32'hFFFFFFFF, 32'h0, 1'b1);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        sleep_request_n <= 1'b1;
        wait_data();
        apb(1'b1, TBS_STATUS_OFS, 32'h0, 32'h0, 1'b0);
        apb(1'b0, TBS_STATUS_OFS, 32'h0, ST_DATA, 1'b0);
        apb(1'b0, TBS_SYNCCNT_OFS, 32'h0, 32'h0, 1'b0);
        send_words(20);
        apb(1'b0, TBS_WORD_OFS, 32'h0, {22'h0, data_in}, 1'b0);
        // Freeze right after a frame, so the strobe is low; no frame may leave while frozen.
        do
        begin
            @(posedge pclk);
        end
        while (link_frame_strobe !== 1'b1);
        pclken <= 1'b0;
        repeat (40)
        begin
            @(posedge pclk);
            check("frozen strobe", 32'h0, 32'(link_frame_strobe));
        end
        pclken <= 1'b1;
        capture_edge_select <= 1'b0;
        repeat (40) @(posedge pclk);
        send_words(20);
        apb(1'b1, TBS_CTRL_OFS, 32'h3, 32'h0, 1'b0);
        apb(1'b0, TBS_CTRL_OFS, 32'h0, 32'h3, 1'b0);
        repeat (24) @(posedge pclk);
        apb(1'b0, TBS_STATUS_OFS, 32'h0, ST_SYNC, 1'b0);
        apb(1'b1, TBS_CTRL_OFS, 32'h2, 32'h0, 1'b0);
        wait_data();
        resync_request_b <= 1'b1;
        repeat (40) @(posedge pclk);
        resync_request_b <= 1'b0;
        repeat (1600) @(posedge pclk);
        apb(1'b0, TBS_STATUS_OFS, 32'h0, ST_SYNC, 1'b0);
        wait_data();
        send_words(8);
        output_drive_enable <= 1'b0;
        repeat (24) @(posedge pclk);
        output_drive_enable <= 1'b1;
        wait_data();
        send_words(8);
        sleep_request_n <= 1'b0;
        repeat (40) @(posedge pclk);
        apb(1'b0, TBS_STATUS_OFS, 32'h0, ST_SLEEP, 1'b0);
        sleep_request_n <= 1'b1;
        wait_data();
        send_words(8);
        check("word queue depth", 32'h0, 32'(word_q.size()));
        stop_test();
    end
endmodule // tbs_serializer_test

//--- rtl/tbs_pin_sync.sv
`timescale 1ns/1ps
module tbs_pin_sync #(
    parameter int W = 16
) (
    // Clock, reset and enable.
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         pclken,
    // Raw pins and their synchronized forms.
    input  wire logic [W-1:0] pin_raw,
    output logic      [W-1:0] pin_sync,
    output logic      [W-1:0] pin_rise,
    output logic      [W-1:0] pin_fall
);

    logic [W-1:0] stage_one;
    logic [W-1:0] pin_prev;

    // Two flip-flops guard against metastability; only the second one is looked at.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage_one <= '0;
            pin_sync  <= '0;
            pin_prev  <= '0;
        end
        else if (pclken)
        begin
            stage_one <= pin_raw;
            pin_sync  <= stage_one;
            pin_prev  <= pin_sync;
        end
    end

    // Edges compare the settled value with its previous copy.
    assign pin_rise = pin_sync & ~pin_prev;
    assign pin_fall = ~pin_sync & pin_prev;

endmodule // tbs_pin_sync

//--- rtl/tbs_pkg.sv
package tbs_pkg;

    // Word and frame geometry.
    localparam int TBS_WORD_W  = 10;
    localparam int TBS_FRAME_W = 12;
    localparam int TBS_PIN_W   = 16;

    // Throughput figures; the payload rate is word width times the top transmit clock.
    localparam int TBS_TOP_TX_MHZ      = 66;
    localparam int TBS_TOP_RATE_MBPS   = 660;
    localparam int TBS_PAYLOAD_BITS    = TBS_TOP_RATE_MBPS / TBS_TOP_TX_MHZ;

    // Embedded clock bits framing each word.
    localparam logic TBS_CLK_BIT_START = 1'b1;
    localparam logic TBS_CLK_BIT_STOP  = 1'b0;

    // Synchronization symbol payload, a single long run of ones then zeros.
    localparam logic [TBS_WORD_W-1:0] TBS_SYNC_PATTERN = 10'h3E0;

    // PLL settle window in transmit clock periods; the block waits 511, the midpoint rounded down.
    localparam int TBS_SETTLE_MIN_PERIODS = 510;
    localparam int TBS_SETTLE_MAX_PERIODS = 513;
    localparam logic [9:0] TBS_SETTLE_PERIODS =
        10'((TBS_SETTLE_MIN_PERIODS + TBS_SETTLE_MAX_PERIODS) / 2);

    // Least number of synchronization symbols per request.
    localparam logic [10:0] TBS_SYNC_MIN_SYMBOLS = 11'h400;

    // Register byte offsets.
    localparam logic [11:0] TBS_CTRL_OFS   = 12'h000;
    localparam logic [11:0] TBS_STATUS_OFS = 12'h004;
    localparam logic [11:0] TBS_SYNCCNT_OFS = 12'h008;
    localparam logic [11:0] TBS_WORD_OFS   = 12'h00C;

    // Control register fields and reset value.
    localparam int TBS_CTRL_SYNC_BIT  = 0;
    localparam int TBS_CTRL_DRIVE_BIT = 1;
    localparam logic [1:0] TBS_CTRL_RST = 2'h2;

    // Status register fields.
    localparam int TBS_ST_LOCKED_BIT = 0;
    localparam int TBS_ST_SYNC_BIT   = 1;
    localparam int TBS_ST_SLEEP_BIT  = 2;
    localparam int TBS_ST_DRIVE_BIT  = 3;

    // Pin bundle positions inside the synchronizer vector.
    localparam int TBS_PIN_TXCLK = 10;
    localparam int TBS_PIN_EDGE  = 11;
    localparam int TBS_PIN_RQA   = 12;
    localparam int TBS_PIN_RQB   = 13;
    localparam int TBS_PIN_DRIVE = 14;
    localparam int TBS_PIN_AWAKE = 15;

    // Link states, Gray coded along sleep, locking, sync, data.
    typedef enum logic [1:0] {
        TBS_SLEEP   = 2'h2,
        TBS_LOCKING = 2'h0,
        TBS_SYNC    = 2'h1,
        TBS_DATA    = 2'h3
    } tbs_state_t;

endpackage

//--- rtl/tbs_serializer.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Operation
// - every transmit period one input word leaves as a frame with two clock bits.
// - payload is ten bits per word, up to 660 Mbps at top clock.
// - after power-up or sleep wait 510 to 513 transmit periods before valid frames.
// - either resync request input high sends sync symbols instead of data.
// - both ends reach phase lock by data lock or sync symbols first.
// - floating the output loses receiver lock; resync before data resumes.
// - capture on rising transmit clock edge if select high, else falling.
// - a sync request sends at least 1024 symbols, more while it stays high.
// - drive enable low floats the output; high resumes the previous state.
// - sleep request low stops the PLL and floats outputs; high reinitializes.
module tbs_serializer
    import tbs_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   pclken,
    // APB slave.
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Parallel side pins.
    input  wire logic [TBS_WORD_W-1:0]  data_in,
    input  wire logic                   transmit_clock,
    input  wire logic                   capture_edge_select,
    input  wire logic                   resync_request_a,
    input  wire logic                   resync_request_b,
    input  wire logic                   output_drive_enable,
    input  wire logic                   sleep_request_n,
    // Frame handed to the line driver.
    output logic      [TBS_FRAME_W-1:0] link_frame,
    output logic                        link_frame_strobe,
    output logic                        link_drive_en
);

    // Synchronized pins.
    logic [TBS_PIN_W-1:0] pin_raw;
    logic [TBS_PIN_W-1:0] pin_sync;
    logic [TBS_PIN_W-1:0] pin_rise;
    logic [TBS_PIN_W-1:0] pin_fall;

    // Link state.
    tbs_state_t             state;
    tbs_state_t             next_state;
    logic [9:0]             settle_cnt;
    logic [10:0]            sync_cnt;
    logic [TBS_WORD_W-1:0]  last_word;

    // Software control.
    logic [1:0]             ctrl;

    // Builds one line frame with its embedded clock bits.
    function automatic logic [TBS_FRAME_W-1:0] make_frame(input logic [TBS_WORD_W-1:0] w);
        make_frame = {TBS_CLK_BIT_START, w, TBS_CLK_BIT_STOP};
    endfunction

    // Every pin crosses into the pclk domain before any logic reads it.
    assign pin_raw = {sleep_request_n, output_drive_enable, resync_request_b,
                      resync_request_a, capture_edge_select, transmit_clock, data_in};

    tbs_pin_sync #(
        .W       (TBS_PIN_W)
    ) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pclken   (pclken),
        .pin_raw  (pin_raw),
        .pin_sync (pin_sync),
        .pin_rise (pin_rise),
        .pin_fall (pin_fall)
    );

    // Pin levels and transmit clock events after synchronization.
    wire [TBS_WORD_W-1:0] word_s   = pin_sync[TBS_WORD_W-1:0];
    wire                  edge_sel = pin_sync[TBS_PIN_EDGE];
    wire                  tx_rise  = pin_rise[TBS_PIN_TXCLK];
    wire                  tx_fall  = pin_fall[TBS_PIN_TXCLK];
    wire                  drive_s  = pin_sync[TBS_PIN_DRIVE];
    wire                  awake_s  = pin_sync[TBS_PIN_AWAKE];

    // The data bits share the clock's synchronizer depth, so they are stable at its edge.
    wire capture_edge = edge_sel ? tx_rise : tx_fall;

    // Either pin, or the software bit, asks for sync symbols.
    wire sync_req = pin_sync[TBS_PIN_RQA] | pin_sync[TBS_PIN_RQB]
                    | ctrl[TBS_CTRL_SYNC_BIT];

    // Decoded state conditions.
    wire settle_done = tx_rise && (settle_cnt == TBS_SETTLE_PERIODS - 10'h001);
    wire sync_spent  = (sync_cnt >= TBS_SYNC_MIN_SYMBOLS);
    wire emitting    = (state == TBS_SYNC) || (state == TBS_DATA);

    // Next state; losing the sleep input wins over every other transition.
    always_comb
    begin
        next_state = state;
        if (!awake_s)
        begin
            next_state = TBS_SLEEP;
        end
        else
        begin
            case (state)
                TBS_SLEEP:
                begin
                    next_state = TBS_LOCKING;
                end
                TBS_LOCKING:
                begin
                    if (settle_done)
                    begin
                        next_state = sync_req ? TBS_SYNC : TBS_DATA;
                    end
                end
                TBS_DATA:
                begin
                    if (sync_req)
                    begin
                        next_state = TBS_SYNC;
                    end
                end
                TBS_SYNC:
                begin
                    if (!sync_req && sync_spent)
                    begin
                        next_state = TBS_DATA;
                    end
                end
                default:
                begin
                    next_state = TBS_SLEEP;
                end
            endcase
        end
    end

    // State register; drive enable does not touch it, so a floated link resumes as it was.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= TBS_SLEEP;
        end
        else if (pclken)
        begin
            state <= next_state;
        end
    end

    // Settle counter runs in transmit periods while locking and restarts on every wake.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            settle_cnt <= 10'h000;
        end
        else if (pclken)
        begin
            if (state != TBS_LOCKING)
            begin
                settle_cnt <= 10'h000;
            end
            else if (tx_rise)
            begin
                settle_cnt <= settle_cnt + 10'h001;
            end
        end
    end

    // Sync symbols are counted per request and saturate once the minimum is met.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_cnt <= 11'h000;
        end
        else if (pclken)
        begin
            if (state != TBS_SYNC)
            begin
                sync_cnt <= 11'h000;
            end
            else if (capture_edge && !sync_spent)
            begin
                sync_cnt <= sync_cnt + 11'h001;
            end
        end
    end

    // One frame per capture edge; nothing valid leaves before the PLL has settled.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_frame        <= '0;
            link_frame_strobe <= 1'b0;
            last_word         <= '0;
        end
        else if (pclken)
        begin
            link_frame_strobe <= capture_edge && emitting;
            if (capture_edge && (state == TBS_DATA))
            begin
                link_frame <= make_frame(word_s);
                last_word  <= word_s;
            end
            else if (capture_edge && (state == TBS_SYNC))
            begin
                link_frame <= make_frame(TBS_SYNC_PATTERN);
            end
        end
    end

    // The line floats in sleep, while settling, or when either enable is low.
    // Floating costs the receiver its lock; its indicator then requests resync.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_drive_en <= 1'b0;
        end
        else if (pclken)
        begin
            link_drive_en <= drive_s && ctrl[TBS_CTRL_DRIVE_BIT] && emitting;
        end
    end

    // APB decode; pready is registered, so every access has one wait state.
    wire access   = psel && penable;
    wire commit   = access && pready;
    wire hit_ctrl = (paddr == TBS_CTRL_OFS);
    wire hit_stat = (paddr == TBS_STATUS_OFS);
    wire hit_sync = (paddr == TBS_SYNCCNT_OFS);
    wire hit_word = (paddr == TBS_WORD_OFS);
    wire hit_any  = hit_ctrl || hit_stat || hit_sync || hit_word;

    // Read data selection; unmapped addresses read as zero.
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
        begin
            rd_mux[1:0] = ctrl;
        end
        else if (hit_stat)
        begin
            rd_mux[TBS_ST_LOCKED_BIT] = emitting;
            rd_mux[TBS_ST_SYNC_BIT]   = (state == TBS_SYNC);
            rd_mux[TBS_ST_SLEEP_BIT]  = (state == TBS_SLEEP);
            rd_mux[TBS_ST_DRIVE_BIT]  = link_drive_en;
        end
        else if (hit_sync)
        begin
            rd_mux[10:0] = sync_cnt;
        end
        else if (hit_word)
        begin
            rd_mux[TBS_WORD_W-1:0] = last_word;
        end
    end

    // Bus answer registers; the answer lands one cycle into the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (pclken)
        begin
            pready  <= access && !pready;
            pslverr <= access && !pready && !hit_any;
            prdata  <= (access && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Control register takes writes only at the completing edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= TBS_CTRL_RST;
        end
        else if (pclken)
        begin
            if (commit && pwrite && hit_ctrl)
            begin
                ctrl <= pwdata[1:0];
            end
        end
    end

endmodule // tbs_serializer
